// file: core/mfu_loader.sv
// firmware upgrade loader: register window, unlock, packet commit, idle fallback
// Operation
// - loader registers answer only while the loader runs, not the application.
// - baud register accepts codes 0 to 8, 2400 up to 115200 baud.
// - baud choice is lost on reboot; default 9600 after power-up.
// - unlock needs both keys 0x7CA2, 0x3A1D in one two-register write.
// - first valid packet erases the application memory before its acknowledge.
// - later packets are acknowledged quickly, about 400 ms at 115.2k.
// - for writes over 256 bytes the byte count is ignored.
// - reading the sequence register returns the last committed packet number.
// - after activity then 3 idle minutes, launch the primary application.
// - an upgrade started but unfinished launches the failsafe application instead.
module mfu_loader
  import mfu_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = 16'h0101,  // arbitrary value
  parameter logic [15:0] MAP_VERSION = 16'h0001, // arbitrary value
  parameter int TICK_CYCLES = MS_CYCLES,
  parameter int IDLE_LIMIT_MS = IDLE_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic app_running_i,
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_valid_o,
  output logic rd_err_o,
  output logic [15:0] rd_data_o,
  input wire logic wr_start_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [15:0] wr_count_i,
  input wire logic [15:0] wr_bytes_i,
  input wire logic wr_word_valid_i,
  input wire logic [15:0] wr_word_i,
  input wire logic wr_end_i,
  input wire logic wr_abort_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [7:0] rsp_code_o,
  output logic [3:0] baud_sel_o,
  output logic erase_req_o,
  input wire logic erase_done_i,
  output logic mem_we_o,
  output logic [23:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic launch_primary_o,
  output logic launch_failsafe_o
);
  typedef struct packed {
    mfu_state_t st;
    logic [15:0] base;
    logic [15:0] cnt;
    logic [15:0] idx;
    logic fail;
    logic [7:0] code;
    logic [15:0] key1;
    logic [15:0] key2;
    logic [3:0] baud_new;
    logic baud_wr;
    logic [15:0] seq_new;
    logic [15:0] seq_done;
    logic unlocked;
    logic erased;
    logic complete;
    logic [8:0] copy_idx;
    logic [8:0] copy_words;
    logic copy_pend;
    logic [15:0] ms_cnt;
    logic [17:0] idle_ms;
    logic seen;
    logic [3:0] baud;
    logic rsp_valid;
    logic rsp_err;
    logic [7:0] rsp_code;
    logic rd_valid;
    logic rd_err;
    logic [15:0] rd_data;
    logic erase_req;
    logic mem_we;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata;
    logic launch_p;
    logic launch_f;
  } mfu_loader_t;

  mfu_loader_t s_q;
  mfu_loader_t s_d;
  logic buf_we;
  logic [7:0] buf_waddr;
  logic [15:0] buf_rdata;
  logic [15:0] tgt;
  logic [15:0] pay_off;
  logic [16:0] span_end;

  assign tgt = s_q.base + s_q.idx;
  assign pay_off = tgt - REG_PAYLOAD;
  assign span_end = {1'b0, wr_addr_i} + {1'b0, wr_count_i} - 17'h00001;
  assign buf_we = (s_q.st == ST_RECV) && wr_word_valid_i && (s_q.base == REG_SEQ)
                  && (tgt >= REG_PAYLOAD) && (pay_off < BYTE_LIMIT);
  assign buf_waddr = pay_off[7:0];

  mfu_pkt_buf #(.WIDTH(16), .DEPTH(256), .AW(8)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(buf_we),
    .waddr_i(buf_waddr),
    .wdata_i(wr_word_i),
    .raddr_i(s_q.copy_idx[7:0]),
    .rdata_o(buf_rdata)
  );

  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.mem_we = 1'b0;
    // register reads
    if (rd_req_i) begin
      s_d.rd_valid = 1'b1;
      s_d.rd_err = 1'b0;
      s_d.rd_data = WO_READ_VALUE;
      if (app_running_i || rd_addr_i < REG_FW_VER || rd_addr_i > REG_PAYLOAD_LAST) begin
        s_d.rd_err = 1'b1;
      end else if (rd_addr_i == REG_FW_VER) begin
        s_d.rd_data = FW_VERSION;
      end else if (rd_addr_i == REG_MAP_VER) begin
        s_d.rd_data = MAP_VERSION;
      end else if (rd_addr_i == REG_PRESENT) begin
        s_d.rd_data = PRESENT_VALUE;
      end else if (rd_addr_i == REG_BAUD) begin
        s_d.rd_data = {12'h000, s_q.baud};
      end else if (rd_addr_i == REG_SEQ) begin
        s_d.rd_data = s_q.seq_done;
      end
    end
    if (rd_req_i || wr_start_i) begin
      s_d.seen = 1'b1;
      s_d.ms_cnt = '0;
      s_d.idle_ms = '0;
    end else if (s_q.ms_cnt == 16'(TICK_CYCLES - 1)) begin
      s_d.ms_cnt = '0;
      if (s_q.idle_ms != 18'(IDLE_LIMIT_MS)) begin
        s_d.idle_ms = s_q.idle_ms + 18'h00001;
      end
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (wr_start_i) begin
          s_d.st = ST_RECV;
          s_d.base = wr_addr_i;
          s_d.cnt = wr_count_i;
          s_d.idx = '0;
          s_d.fail = 1'b0;
          s_d.baud_wr = 1'b0;
          s_d.key1 = '0;
          s_d.key2 = '0;
          if (app_running_i || wr_count_i == 16'h0000 || wr_addr_i < REG_FW_VER
              || span_end > {1'b0, REG_PAYLOAD_LAST}) begin
            s_d.fail = 1'b1;
            s_d.code = ERR_ADDR;
          // byte count ignored above 256 bytes
          end else if ({wr_count_i[14:0], 1'b0} <= BYTE_LIMIT
                       && wr_bytes_i != {wr_count_i[14:0], 1'b0}) begin
            s_d.fail = 1'b1;
            s_d.code = ERR_SIZE;
          end
        end else if (s_q.seen && s_q.idle_ms == 18'(IDLE_LIMIT_MS)
                     && !s_q.launch_p && !s_q.launch_f) begin
          if (s_q.erased && !s_q.complete) begin
            s_d.launch_f = 1'b1;
          end else begin
            s_d.launch_p = 1'b1;
          end
        end
      end
      ST_RECV: begin
        if (wr_abort_i) begin
          s_d.st = ST_IDLE;
        end else if (wr_word_valid_i) begin
          s_d.idx = s_q.idx + 16'h0001;
          if (tgt == REG_BAUD) begin
            if (wr_word_i > {12'h000, BAUD_MAX}) begin
              s_d.fail = 1'b1;
              s_d.code = ERR_ARG;
            end else begin
              s_d.baud_new = wr_word_i[3:0];
              s_d.baud_wr = 1'b1;
            end
          end else if (tgt == REG_KEY1) begin
            s_d.key1 = wr_word_i;
          end else if (tgt == REG_KEY2) begin
            s_d.key2 = wr_word_i;
          end else if (tgt == REG_SEQ) begin
            s_d.seq_new = wr_word_i;
          end
        end else if (wr_end_i) begin
          s_d.st = ST_IDLE;
          s_d.rsp_valid = 1'b1;
          s_d.rsp_err = 1'b0;
          if (s_q.fail) begin
            s_d.rsp_err = 1'b1;
            s_d.rsp_code = s_q.code;
          end else begin
            if (s_q.baud_wr) begin
              s_d.baud = s_q.baud_new;
            end
            // both keys in one two-register write
            if (s_q.base == REG_KEY1 && s_q.cnt == 16'h0002
                && s_q.key1 == KEY1_VALUE && s_q.key2 == KEY2_VALUE) begin
              s_d.unlocked = 1'b1;
            end
            if (s_q.base == REG_SEQ) begin
              if (!s_q.unlocked) begin
                s_d.rsp_err = 1'b1;
                s_d.rsp_code = ERR_NOT_READY;
              end else if (s_q.seq_new == s_q.seq_done) begin
                // repeat of a committed packet is acknowledged again
                s_d.rsp_err = 1'b0;
              end else if (s_q.seq_new == s_q.seq_done + 16'h0001) begin
                s_d.rsp_valid = 1'b0;
                s_d.copy_idx = '0;
                s_d.copy_pend = 1'b0;
                s_d.copy_words = 9'(s_q.cnt - 16'h0001);
                // a short packet marks the end of the image
                if (s_q.cnt < PACKET_REGS) begin
                  s_d.complete = 1'b1;
                end
                if (!s_q.erased) begin
                  s_d.st = ST_ERASE;
                  s_d.erase_req = 1'b1;
                end else begin
                  s_d.st = ST_COPY;
                end
              end else begin
                s_d.rsp_err = 1'b1;
                s_d.rsp_code = ERR_ARG;
              end
            end
          end
        end
      end
      ST_ERASE: begin
        if (erase_done_i) begin
          s_d.erase_req = 1'b0;
          s_d.erased = 1'b1;
          s_d.st = ST_COPY;
        end
      end
      ST_COPY: begin
        s_d.mem_we = s_q.copy_pend;
        s_d.mem_addr = {s_q.seq_new - 16'h0001, 8'(s_q.copy_idx - 9'h001)};
        s_d.mem_wdata = buf_rdata;
        s_d.copy_pend = s_q.copy_idx < s_q.copy_words;
        if (s_q.copy_idx < s_q.copy_words) begin
          s_d.copy_idx = s_q.copy_idx + 9'h001;
        end else if (!s_q.copy_pend) begin
          s_d.st = ST_IDLE;
          s_d.seq_done = s_q.seq_new;
          s_d.rsp_valid = 1'b1;
          s_d.rsp_err = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.baud <= BAUD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_valid_o = s_q.rd_valid;
  assign rd_err_o = s_q.rd_err;
  assign rd_data_o = s_q.rd_data;
  assign rsp_valid_o = s_q.rsp_valid;
  assign rsp_err_o = s_q.rsp_err;
  assign rsp_code_o = s_q.rsp_code;
  assign baud_sel_o = s_q.baud;
  assign erase_req_o = s_q.erase_req;
  assign mem_we_o = s_q.mem_we;
  assign mem_addr_o = s_q.mem_addr;
  assign mem_wdata_o = s_q.mem_wdata;
  assign launch_primary_o = s_q.launch_p;
  assign launch_failsafe_o = s_q.launch_f;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_copy_exit;
    (s_q.st == ST_COPY) ##1 (s_q.st == ST_IDLE);
  endsequence
  sequence s_erase_wait;
    erase_req_o && !erase_done_i;
  endsequence

  property p_baud_legal;
    baud_sel_o <= BAUD_MAX;
  endproperty
  a_baud_legal: assert property (p_baud_legal) else $error("baud code out of range");
  property p_baud_reset;
    $past(rst_i) |-> baud_sel_o == BAUD_RESET;
  endproperty
  a_baud_reset: assert property (@(posedge clk_i) p_baud_reset) else $error("baud not default");
  property p_app_lock;
    rd_req_i && app_running_i |=> rd_valid_o && rd_err_o;
  endproperty
  a_app_lock: assert property (p_app_lock) else $error("read answered under application");
  property p_key;
    $rose(s_q.unlocked) |-> $past(s_q.key1 == KEY1_VALUE && s_q.key2 == KEY2_VALUE
                                 && s_q.base == REG_KEY1 && s_q.cnt == 16'h0002);
  endproperty
  a_key: assert property (p_key) else $error("unlock without key pair");
  property p_erase_first;
    mem_we_o |-> s_q.erased && s_q.unlocked;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("write before erase or unlock");
  property p_erase_hold;
    s_erase_wait |=> erase_req_o && !rsp_valid_o;
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase dropped early");
  property p_ack_after_copy;
    s_copy_exit |-> rsp_valid_o && !rsp_err_o && s_q.seq_done == s_q.seq_new;
  endproperty
  a_ack_after_copy: assert property (p_ack_after_copy) else $error("commit not acknowledged");
  property p_seq_step;
    $changed(s_q.seq_done) |-> s_q.seq_done == $past(s_q.seq_done) + 16'h0001;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence skipped");
  property p_bytes_ignored;
    (s_q.st == ST_IDLE) && wr_start_i && !app_running_i && wr_addr_i == REG_SEQ
      && wr_count_i == PACKET_REGS |=> !s_q.fail;
  endproperty
  a_bytes_ignored: assert property (p_bytes_ignored) else $error("byte count checked");
  property p_idle_launch;
    $rose(launch_primary_o || launch_failsafe_o) |-> s_q.seen && s_q.st == ST_IDLE;
  endproperty
  a_idle_launch: assert property (p_idle_launch) else $error("launch without idle");
  property p_failsafe;
    launch_failsafe_o |-> s_q.erased && !s_q.complete;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("failsafe without partial image");
endmodule // mfu_loader

// file: core/mfu_pkg.sv
// constants, register map and state encoding of the firmware upgrade loader
package mfu_pkg;
  // register word addresses
  localparam logic [15:0] REG_FW_VER = 16'h018E;
  localparam logic [15:0] REG_MAP_VER = 16'h018F;
  localparam logic [15:0] REG_PRESENT = 16'h0190;
  localparam logic [15:0] REG_BAUD = 16'h0191;
  localparam logic [15:0] REG_KEY1 = 16'h0192;
  localparam logic [15:0] REG_KEY2 = 16'h0193;
  localparam logic [15:0] REG_SEQ = 16'h0194;
  localparam logic [15:0] REG_PAYLOAD = 16'h0195;
  localparam logic [15:0] REG_PAYLOAD_LAST = 16'h0295;
  // unlock key values and fixed read values
  localparam logic [15:0] KEY1_VALUE = 16'h7CA2;
  localparam logic [15:0] KEY2_VALUE = 16'h3A1D;
  localparam logic [15:0] PRESENT_VALUE = 16'h0001;
  localparam logic [15:0] WO_READ_VALUE = 16'h0000;
  // baud codes 0..8 = 2400,4800,9600,14400,19200,28800,38400,57600,115200
  localparam logic [3:0] BAUD_RESET = 4'h2;
  localparam logic [3:0] BAUD_MAX = 4'h8;
  // packet geometry: sequence word plus up to 256 data words
  localparam logic [15:0] PACKET_REGS = 16'h0101;
  localparam logic [15:0] BYTE_LIMIT = 16'h0100;
  // error codes in the reply
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_SIZE = 8'h03;
  localparam logic [7:0] ERR_ARG = 8'h04;
  localparam logic [7:0] ERR_NOT_READY = 8'h06;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int IDLE_TIMEOUT_S = 180;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int IDLE_MS = IDLE_TIMEOUT_S * 1000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_ERASE = 2'b10,
    ST_COPY = 2'b11
  } mfu_state_t;
endpackage

// file: core/mfu_pkt_buf.sv
// packet staging memory with registered read data
module mfu_pkt_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // mfu_pkt_buf

// file: bench/mfu_host_model.sv
// host model: drives register reads and multi-register write messages
module mfu_host_model (
  input wire logic clk_i,
  input wire logic rd_valid_i,
  input wire logic rd_err_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_err_i,
  input wire logic [7:0] rsp_code_i,
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  output logic wr_start_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_count_o,
  output logic [15:0] wr_bytes_o,
  output logic wr_word_valid_o,
  output logic [15:0] wr_word_o,
  output logic wr_end_o,
  output logic wr_abort_o,
  output logic timeout_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_req_o = 1'b0;
    rd_addr_o = 16'h0000;
    wr_start_o = 1'b0;
    wr_addr_o = 16'h0000;
    wr_count_o = 16'h0000;
    wr_bytes_o = 16'h0000;
    wr_word_valid_o = 1'b0;
    wr_word_o = 16'h0000;
    wr_end_o = 1'b0;
    wr_abort_o = 1'b0;
    timeout_o = 1'b0;
  end

  function automatic logic [15:0] word(input int k, input logic [15:0] w0, input logic [15:0] w1);
    return (k == 0) ? w0 : ((k == 1) ? w1 : (16'hA500 ^ 16'(k)));
  endfunction

  task automatic rd(input logic [15:0] a, output logic err, output logic [15:0] d);
    int i;
    @(posedge clk_i);
    rd_req_o <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_i);
    rd_req_o <= 1'b0;
    // answer is launched by this edge, so look at it half a cycle later
    @(negedge clk_i);
    for (i = 0; i < 8 && rd_valid_i !== 1'b1; i++) @(negedge clk_i);
    if (i == 8) timeout_o = 1'b1;
    err = rd_err_i;
    d = rd_data_i;
  endtask

  task automatic wr(input logic [15:0] a, n, b, w0, w1, output logic err, output logic [7:0] code);
    int i;
    @(posedge clk_i);
    wr_start_o <= 1'b1;
    wr_addr_o <= a;
    wr_count_o <= n;
    wr_bytes_o <= b;
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      wr_start_o <= 1'b0;
      wr_word_valid_o <= 1'b1;
      wr_word_o <= word(i, w0, w1);
    end
    @(posedge clk_i);
    wr_start_o <= 1'b0;
    wr_word_valid_o <= 1'b0;
    wr_end_o <= 1'b1;
    @(posedge clk_i);
    wr_end_o <= 1'b0;
    @(negedge clk_i);
    for (i = 0; i < 2000 && rsp_valid_i !== 1'b1; i++) @(negedge clk_i);
    if (i == 2000) timeout_o = 1'b1;
    err = rsp_err_i;
    code = rsp_code_i;
  endtask

  // one-word write cut short by a discarded frame: no reply is due
  task automatic cut(input logic [15:0] a, w0);
    @(posedge clk_i);
    wr_start_o <= 1'b1;
    wr_addr_o <= a;
    wr_count_o <= 16'h0001;
    wr_bytes_o <= 16'h0002;
    @(posedge clk_i);
    wr_start_o <= 1'b0;
    wr_word_valid_o <= 1'b1;
    wr_word_o <= w0;
    @(posedge clk_i);
    wr_word_valid_o <= 1'b0;
    wr_abort_o <= 1'b1;
    @(posedge clk_i);
    wr_abort_o <= 1'b0;
  endtask
endmodule // mfu_host_model

// file: bench/tb_mfu_loader.sv
// self-checking bench for the firmware upgrade loader
module tb_mfu_loader
  import mfu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic app_running = 1'b0;
  logic erase_done = 1'b0;
  logic rd_req, wr_start, word_valid, wr_end, wr_abort, timed_out;
  logic rd_valid, rd_err, rsp_valid, rsp_err, erase_req, mem_we, launch_p, launch_f;
  logic [15:0] rd_addr, wr_addr, wr_count, wr_bytes, word, rd_data, mem_wdata;
  logic [7:0] rsp_code;
  logic [3:0] baud_sel;
  logic [23:0] mem_addr;
  int errors = 0;
  int check_count = 0;
  int ecnt = 0;
  int erases = 0;
  int writes = 0;
  int idx = 0;
  logic [15:0] exp_seq = 16'h0000;
  logic e;
  logic [7:0] c;
  logic [15:0] d;

  always #12.5 clk_i = ~clk_i;

  // short idle limit: 4-cycle tick, 200 ticks
  mfu_loader #(.TICK_CYCLES(4), .IDLE_LIMIT_MS(200)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .app_running_i(app_running),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid),
    .rd_err_o(rd_err), .rd_data_o(rd_data), .wr_start_i(wr_start),
    .wr_addr_i(wr_addr), .wr_count_i(wr_count), .wr_bytes_i(wr_bytes),
    .wr_word_valid_i(word_valid), .wr_word_i(word), .wr_end_i(wr_end),
    .wr_abort_i(wr_abort), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err),
    .rsp_code_o(rsp_code), .baud_sel_o(baud_sel), .erase_req_o(erase_req),
    .erase_done_i(erase_done), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .launch_primary_o(launch_p), .launch_failsafe_o(launch_f));

  mfu_host_model host (
    .clk_i(clk_i), .rd_valid_i(rd_valid), .rd_err_i(rd_err), .rd_data_i(rd_data),
    .rsp_valid_i(rsp_valid), .rsp_err_i(rsp_err), .rsp_code_i(rsp_code),
    .rd_req_o(rd_req), .rd_addr_o(rd_addr), .wr_start_o(wr_start),
    .wr_addr_o(wr_addr), .wr_count_o(wr_count), .wr_bytes_o(wr_bytes),
    .wr_word_valid_o(word_valid), .wr_word_o(word), .wr_end_o(wr_end),
    .wr_abort_o(wr_abort), .timeout_o(timed_out));

  // flash eraser stays busy 21 cycles so the slow first reply is really exercised
  always @(posedge clk_i) begin
    ecnt <= erase_req ? ecnt + 1 : 0;
    erase_done <= erase_req && ecnt == 20;
  end

  always @(posedge erase_req) erases++;

  always @(negedge clk_i) begin
    if (rsp_valid === 1'b1 && erase_req === 1'b1) check(24'h000001, 24'h000000);
    if (mem_we === 1'b1) begin
      check(mem_addr, {exp_seq - 16'h0001, idx[7:0]});
      check({8'h00, mem_wdata}, {8'h00, 16'hA500 ^ 16'(idx + 1)});
      idx++;
      writes++;
    end
  end

  always @(posedge timed_out) begin
    errors++;
    conclude();
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic ee, input logic [15:0] ed);
    host.rd(a, e, d);
    check({23'h000000, e}, {23'h000000, ee});
    if (!ee) check({8'h00, d}, {8'h00, ed});
  endtask

  task automatic wr_chk(input logic [15:0] a, n, b, w0, w1, input logic ee, input logic [7:0] ec);
    host.wr(a, n, b, w0, w1, e, c);
    check({23'h000000, e}, {23'h000000, ee});
    if (ee) check({16'h0000, c}, {16'h0000, ec});
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic wait_launch();
    int i;
    for (i = 0; i < 3000 && launch_p !== 1'b1 && launch_f !== 1'b1; i++) @(negedge clk_i);
    if (i == 3000) begin
      errors++;
      conclude();
    end
  endtask

  // unlock, then a full first packet whose byte-count field is left wrong on purpose
  task automatic load_first();
    wr_chk(REG_KEY1, 16'h0002, 16'h0004, KEY1_VALUE, KEY2_VALUE, 1'b0, 8'h00);
    exp_seq = 16'h0001;
    idx = 0;
    writes = 0;
    erases = 0;
    wr_chk(REG_SEQ, PACKET_REGS, 16'h0000, 16'h0001, 16'hA501, 1'b0, 8'h00);
    check(24'(writes), 24'h000100);
    check(24'(erases), 24'h000001);
    rd_chk(REG_SEQ, 1'b0, 16'h0001);
  endtask

  initial begin
    do_reset();
    check({20'h00000, baud_sel}, {20'h00000, BAUD_RESET});
    rd_chk(REG_PRESENT, 1'b0, PRESENT_VALUE);
    rd_chk(REG_SEQ, 1'b0, 16'h0000);
    rd_chk(REG_KEY2, 1'b0, WO_READ_VALUE);
    rd_chk(16'h0300, 1'b1, 16'h0000);
    @(posedge clk_i);
    app_running <= 1'b1;
    rd_chk(REG_PRESENT, 1'b1, 16'h0000);
    @(posedge clk_i);
    app_running <= 1'b0;
    for (int k = 0; k <= 8; k++) begin
      wr_chk(REG_BAUD, 16'h0001, 16'h0002, 16'(k), 16'h0000, 1'b0, 8'h00);
      check({20'h00000, baud_sel}, 24'(k));
      rd_chk(REG_BAUD, 1'b0, 16'(k));
    end
    rd_chk(REG_PRESENT, 1'b0, PRESENT_VALUE);
    wr_chk(REG_BAUD, 16'h0001, 16'h0002, 16'h0009, 16'h0000, 1'b1, ERR_ARG);
    wr_chk(REG_BAUD, 16'h0001, 16'h0003, 16'h0001, 16'h0000, 1'b1, ERR_SIZE);
    check({20'h00000, baud_sel}, 24'h000008);
    host.cut(REG_BAUD, 16'h0003);
    @(negedge clk_i);
    check({23'h000000, rsp_valid}, 24'h000000);
    check({20'h00000, baud_sel}, 24'h000008);
    wr_chk(REG_SEQ, 16'h0003, 16'h0006, 16'h0001, 16'hA501, 1'b1, ERR_NOT_READY);
    host.wr(REG_KEY1, 16'h0002, 16'h0004, KEY1_VALUE, 16'h3A1C, e, c);
    wr_chk(REG_SEQ, 16'h0003, 16'h0006, 16'h0001, 16'hA501, 1'b1, ERR_NOT_READY);
    check(24'(writes), 24'h000000);
    do_reset();
    check({20'h00000, baud_sel}, {20'h00000, BAUD_RESET});
    load_first();
    // a repeat of the committed packet is acknowledged but not written again
    wr_chk(REG_SEQ, PACKET_REGS, 16'h0000, 16'h0001, 16'hA501, 1'b0, 8'h00);
    wr_chk(REG_SEQ, 16'h0003, 16'h0006, 16'h0003, 16'hA501, 1'b1, ERR_ARG);
    rd_chk(REG_SEQ, 1'b0, 16'h0001);
    check(24'(writes), 24'h000100);
    wait_launch();
    check({22'h000000, launch_f, launch_p}, 24'h000002);
    do_reset();
    load_first();
    exp_seq = 16'h0002;
    idx = 0;
    wr_chk(REG_SEQ, 16'h0004, 16'h0008, 16'h0002, 16'hA501, 1'b0, 8'h00);
    check(24'(writes), 24'h000103);
    check(24'(erases), 24'h000001);
    wait_launch();
    check({22'h000000, launch_f, launch_p}, 24'h000001);
    conclude();
  end
endmodule // tb_mfu_loader
